// ### mfc_host.sv
// host model issuing single-word commands to the configuration bank
module mfc_host
    import mfc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [15:0] rd_data,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic      [7:0]  cmd_code,
    output logic      [15:0] cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // one strobe per access; request held until the taking edge
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code  <= c;
        // phase codes above six phases are never sent
        cmd_wdata <= (c == CMD_PHASE_COUNT && d[2:0] > 3'h5) ? {d[15:3], 3'h5} : d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // idle bus must not look like the last data
        cmd_wdata <= ~d;
        #1;
        q = rd_data;
    endtask : acc
endmodule : mfc_host

// ### mfc_pkg.sv
// constants and decode functions for the multiphase fault configuration bank
// Function
// RULE1: share warning turns phase off unless keep set
// RULE2: threshold codes 000-011 give 2/4/6/8 A
// RULE3: codes 100-111 give 10/15/20 A, off
// RULE4: phase count writable while running, applied live
// RULE5: phase count equals code plus one
// RULE6: host never writes phase codes 110, 111
// RULE7: excessive phase count leaves previous count kept
// RULE8: rejected count sets status bit 3, alert
// RULE9: tracking OV = command plus 175-325 mV
// RULE10: fixed OV = max plus 50-400 mV
// RULE11: UV = command minus droop minus offset
// RULE12: UV offset table 50 to 400 mV
// RULE13: boot register holds 8-bit code, low byte
// RULE14: boot code right-justified, bit 0 at 0
// RULE15: six phase-off bits, reset 0, volatile
// RULE16: share imbalance sets IOUT bit 3, alert
// RULE17: reserved bits read zero, writes ignored
package mfc_pkg;

    // ----------------------------------------------------------------
    // command codes and geometry
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_SHARE_CFG   = 8'hE3;
    localparam logic [7:0]  CMD_PHASE_COUNT = 8'hE4;
    localparam logic [7:0]  CMD_OV_OFFSETS  = 8'hE5;
    localparam logic [7:0]  CMD_UV_OFFSET   = 8'hE6;
    localparam logic [7:0]  CMD_BOOT_CODE   = 8'hE7;
    localparam logic [7:0]  CMD_PHASE_MASK  = 8'hE8;

    localparam int          NUM_PHASES      = 6;
    localparam logic [2:0]  MAX_PHASE_CODE  = 3'h5;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          KEEP_BIT        = 7;
    localparam int          SHARE_TH_MSB    = 2;
    localparam int          PHASE_NUM_MSB   = 2;
    localparam int          TRACK_OV_LSB    = 3;
    localparam int          TRACK_OV_MSB    = 4;
    localparam int          FIXED_OV_MSB    = 2;
    localparam int          UV_OFF_MSB      = 2;
    localparam int          BOOT_MSB        = 7;
    localparam int          MASK_MSB        = 5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [2:0]  SHARE_TH_RST    = 3'h3;
    localparam logic        KEEP_RST        = 1'b0;
    localparam logic [1:0]  TRACK_OV_RST    = 2'h1;
    localparam logic [2:0]  FIXED_OV_RST    = 3'h7;
    localparam logic [2:0]  UV_OFF_RST      = 3'h3;
    localparam logic [5:0]  MASK_RST        = 6'h00;

    // ----------------------------------------------------------------
    // offset tables, millivolts and amperes
    // ----------------------------------------------------------------
    localparam logic [11:0] MV_STEP         = 12'h032;
    localparam logic [11:0] TRACK_OV_BASE   = 12'h0AF;
    localparam logic [11:0] UV_CODE6_MV     = 12'h145;

    function automatic logic [11:0] mfc_track_ov_mv(input logic [1:0] code);
        mfc_track_ov_mv = TRACK_OV_BASE + 12'(code) * MV_STEP; // RULE9
    endfunction : mfc_track_ov_mv

    function automatic logic [11:0] mfc_fixed_ov_mv(input logic [2:0] code);
        mfc_fixed_ov_mv = (12'(code) + 12'h001) * MV_STEP; // RULE10
    endfunction : mfc_fixed_ov_mv

    function automatic logic [11:0] mfc_uv_off_mv(input logic [2:0] code);
        // code 110 breaks the 50 mV ladder
        if (code == 3'h6)
            mfc_uv_off_mv = UV_CODE6_MV; // RULE12
        else
            mfc_uv_off_mv = (12'(code) + 12'h001) * MV_STEP; // RULE12
    endfunction : mfc_uv_off_mv

    // returns amperes; code 111 means comparison off
    function automatic logic [4:0] mfc_share_amps(input logic [2:0] code);
        case (code)
            3'h0:    mfc_share_amps = 5'h02; // RULE2
            3'h1:    mfc_share_amps = 5'h04; // RULE2
            3'h2:    mfc_share_amps = 5'h06; // RULE2
            3'h3:    mfc_share_amps = 5'h08; // RULE2
            3'h4:    mfc_share_amps = 5'h0A; // RULE3
            3'h5:    mfc_share_amps = 5'h0F; // RULE3
            3'h6:    mfc_share_amps = 5'h14; // RULE3
            default: mfc_share_amps = 5'h00; // RULE3
        endcase
    endfunction : mfc_share_amps

endpackage : mfc_pkg

// ### mfc_regs.sv
// manufacturer configuration register bank with phase control and alerts
module mfc_regs
    import mfc_pkg::*;
#(
    parameter logic [7:0] BOOT_RESET = 8'h00
)
(
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       cmd_valid,
    input  wire logic                       cmd_write,
    input  wire logic [7:0]                 cmd_code,
    input  wire logic [15:0]                cmd_wdata,
    input  wire logic                       clear_status,
    input  wire logic [2:0]                 hw_phase_code,
    input  wire logic [NUM_PHASES-1:0][7:0] phase_amps,
    input  wire logic [11:0]                vout_command_mv,
    input  wire logic [11:0]                vout_max_mv,
    input  wire logic [11:0]                droop_mv,
    output logic      [15:0]                rd_data,
    output logic      [NUM_PHASES-1:0]      phase_on,
    output logic      [2:0]                 phase_count_code,
    output logic      [7:0]                 boot_code,
    output logic                            status_mfr_bit3,
    output logic                            status_iout_bit3,
    output logic                            alert_output,
    output logic      [11:0]                track_ov_mv,
    output logic      [11:0]                fixed_ov_mv,
    output logic      [11:0]                uv_mv
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic                  phase_fault_keep;
    logic [2:0]            share_threshold_sel;
    logic [1:0]            tracking_overvolt_offset;
    logic [2:0]            fixed_overvolt_offset;
    logic [2:0]            undervolt_offset;
    logic [5:0]            phase_off;
    logic [NUM_PHASES-1:0] fault_off;
    logic                  init_done;
    logic [NUM_PHASES-1:0] warn;

    logic                  next_phase_fault_keep;
    logic [2:0]            next_share_threshold_sel;
    logic [1:0]            next_tracking_overvolt_offset;
    logic [2:0]            next_fixed_overvolt_offset;
    logic [2:0]            next_undervolt_offset;
    logic [5:0]            next_phase_off;
    logic [7:0]            next_boot_code;
    logic [2:0]            next_phase_count_code;
    logic [NUM_PHASES-1:0] next_fault_off;
    logic                  next_init_done;
    logic                  next_status_mfr_bit3;
    logic                  next_status_iout_bit3;
    logic                  next_alert_output;
    logic [15:0]           next_rd_data;
    logic [NUM_PHASES-1:0] next_phase_on;
    logic                  wr;
    logic                  count_reject;

    // ----------------------------------------------------------------
    // write decode and status
    // ----------------------------------------------------------------
    always_comb
    begin
        wr                            = cmd_valid && cmd_write;
        next_phase_fault_keep         = phase_fault_keep;
        next_share_threshold_sel      = share_threshold_sel;
        next_tracking_overvolt_offset = tracking_overvolt_offset;
        next_fixed_overvolt_offset    = fixed_overvolt_offset;
        next_undervolt_offset         = undervolt_offset;
        next_phase_off                = phase_off;
        next_boot_code                = boot_code;
        next_phase_count_code         = phase_count_code;
        next_init_done                = 1'b1;
        count_reject                  = 1'b0;
        // hardware phase count is only known after reset release
        if (!init_done)
            next_phase_count_code = hw_phase_code;
        if (wr)
        begin
            // only named fields are stored; reserved bits drop here
            case (cmd_code)
                CMD_SHARE_CFG:
                begin
                    next_phase_fault_keep    = cmd_wdata[KEEP_BIT]; // RULE17
                    next_share_threshold_sel = cmd_wdata[SHARE_TH_MSB:0];
                end
                CMD_PHASE_COUNT:
                begin
                    // also guards codes 110/111 that the host must avoid
                    if (cmd_wdata[PHASE_NUM_MSB:0] > hw_phase_code) // RULE6
                        count_reject = 1'b1; // RULE7
                    else
                        next_phase_count_code = cmd_wdata[PHASE_NUM_MSB:0]; // RULE4
                end
                CMD_OV_OFFSETS:
                begin
                    next_tracking_overvolt_offset = cmd_wdata[TRACK_OV_MSB:TRACK_OV_LSB];
                    next_fixed_overvolt_offset    = cmd_wdata[FIXED_OV_MSB:0];
                end
                CMD_UV_OFFSET:   next_undervolt_offset = cmd_wdata[UV_OFF_MSB:0];
                CMD_BOOT_CODE:   next_boot_code        = cmd_wdata[BOOT_MSB:0]; // RULE13
                CMD_PHASE_MASK:  next_phase_off        = cmd_wdata[MASK_MSB:0]; // RULE15
                default:         next_boot_code        = boot_code;
            endcase
        end
        // set wins over a clear in the same cycle
        next_status_mfr_bit3  = count_reject | (status_mfr_bit3 & ~clear_status); // RULE8
        next_status_iout_bit3 = (|warn) | (status_iout_bit3 & ~clear_status); // RULE16
        next_alert_output     = next_status_mfr_bit3 | next_status_iout_bit3; // RULE8
        // a phase warned while keep is clear stays off until status is cleared
        next_fault_off = (warn & {NUM_PHASES{~phase_fault_keep}})
                       | (fault_off & {NUM_PHASES{~clear_status}}); // RULE1
    end

    // ----------------------------------------------------------------
    // phase enables and read path
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NUM_PHASES; i++)
            next_phase_on[i] = (3'(i) <= phase_count_code) && !phase_off[i]
                             && !fault_off[i]; // RULE5
        next_rd_data = rd_data;
        if (cmd_valid && !cmd_write)
        begin
            next_rd_data = 16'h0000; // RULE17
            case (cmd_code)
                CMD_SHARE_CFG:
                begin
                    next_rd_data[KEEP_BIT]         = phase_fault_keep;
                    next_rd_data[SHARE_TH_MSB:0]   = share_threshold_sel;
                end
                CMD_PHASE_COUNT: next_rd_data[PHASE_NUM_MSB:0] = phase_count_code;
                CMD_OV_OFFSETS:
                begin
                    next_rd_data[TRACK_OV_MSB:TRACK_OV_LSB] = tracking_overvolt_offset;
                    next_rd_data[FIXED_OV_MSB:0]            = fixed_overvolt_offset;
                end
                CMD_UV_OFFSET:   next_rd_data[UV_OFF_MSB:0] = undervolt_offset;
                CMD_BOOT_CODE:   next_rd_data[BOOT_MSB:0]   = boot_code; // RULE14
                CMD_PHASE_MASK:  next_rd_data[MASK_MSB:0]   = phase_off;
                default:         next_rd_data               = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_fault_keep         <= KEEP_RST; // RULE1
            share_threshold_sel      <= SHARE_TH_RST; // RULE2
            tracking_overvolt_offset <= TRACK_OV_RST;
            fixed_overvolt_offset    <= FIXED_OV_RST;
            undervolt_offset         <= UV_OFF_RST;
            phase_off                <= MASK_RST; // RULE15
            boot_code                <= BOOT_RESET;
            phase_count_code         <= MAX_PHASE_CODE;
            fault_off                <= '0;
            init_done                <= 1'b0;
            status_mfr_bit3          <= 1'b0;
            status_iout_bit3         <= 1'b0;
            alert_output             <= 1'b0;
            rd_data                  <= 16'h0000;
            phase_on                 <= '0;
        end
        else
        begin
            phase_fault_keep         <= next_phase_fault_keep;
            share_threshold_sel      <= next_share_threshold_sel;
            tracking_overvolt_offset <= next_tracking_overvolt_offset;
            fixed_overvolt_offset    <= next_fixed_overvolt_offset;
            undervolt_offset         <= next_undervolt_offset;
            phase_off                <= next_phase_off;
            boot_code                <= next_boot_code;
            phase_count_code         <= next_phase_count_code;
            fault_off                <= next_fault_off;
            init_done                <= next_init_done;
            status_mfr_bit3          <= next_status_mfr_bit3;
            status_iout_bit3         <= next_status_iout_bit3;
            alert_output             <= next_alert_output;
            rd_data                  <= next_rd_data;
            phase_on                 <= next_phase_on;
        end
    end

    // ----------------------------------------------------------------
    // monitors
    // ----------------------------------------------------------------
    mfc_share_mon u_share
    (
        .clk                 (clk),
        .rst_b               (rst_b),
        .phase_amps          (phase_amps),
        .active              (phase_on),
        .share_threshold_sel (share_threshold_sel),
        .warn                (warn)
    );

    mfc_thresh u_thresh
    (
        .clk                      (clk),
        .rst_b                    (rst_b),
        .vout_command_mv          (vout_command_mv),
        .vout_max_mv              (vout_max_mv),
        .droop_mv                 (droop_mv),
        .tracking_overvolt_offset (tracking_overvolt_offset),
        .fixed_overvolt_offset    (fixed_overvolt_offset),
        .undervolt_offset         (undervolt_offset),
        .track_ov_mv              (track_ov_mv),
        .fixed_ov_mv              (fixed_ov_mv),
        .uv_mv                    (uv_mv)
    );

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    keep_off_phase_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        ((|warn) && !phase_fault_keep) |=> ##1 (phase_on & $past(warn, 2)) == '0)
        else $error("warned phase stayed on with keep clear");

    keep_on_phase_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        (phase_fault_keep && $stable(phase_fault_keep) && fault_off == '0
         && phase_off == '0 && init_done && !(wr && cmd_code == CMD_PHASE_MASK))
        |=> ##1 phase_on[0])
        else $error("phase 0 dropped while keep set");

    count_accept_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
        (init_done && wr && cmd_code == CMD_PHASE_COUNT
         && cmd_wdata[2:0] <= hw_phase_code)
        |=> phase_count_code == $past(cmd_wdata[2:0]))
        else $error("valid phase count not applied");

    count_reject_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
        (init_done && wr && cmd_code == CMD_PHASE_COUNT
         && cmd_wdata[2:0] > hw_phase_code)
        |=> $stable(phase_count_code) && status_mfr_bit3 && alert_output)
        else $error("excess phase count not rejected");

    top_phase_off_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
        (phase_count_code == 3'h0) |=> phase_on[NUM_PHASES-1:1] == '0)
        else $error("phases beyond count enabled");

    mask_off_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
        phase_off[3] |=> !phase_on[3])
        else $error("masked phase enabled");

    boot_read_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
        (cmd_valid && !cmd_write && cmd_code == CMD_BOOT_CODE)
        |=> rd_data == {8'h00, $past(boot_code)})
        else $error("boot code readback wrong");

    iout_sticky_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
        (|warn) |=> status_iout_bit3 && alert_output)
        else $error("imbalance did not flag status");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
        ($past(cmd_valid) && !$past(cmd_write) && $past(cmd_code) == CMD_SHARE_CFG)
        |-> rd_data[15:8] == 8'h00 && rd_data[6:3] == 4'h0)
        else $error("reserved bits read nonzero");

endmodule : mfc_regs

// ### mfc_share_mon.sv
// per-phase current imbalance detector against the mean of active phases
module mfc_share_mon
    import mfc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [NUM_PHASES-1:0][7:0] phase_amps,
    input  wire logic [NUM_PHASES-1:0]      active,
    input  wire logic [2:0]                 share_threshold_sel,
    output logic      [NUM_PHASES-1:0]      warn
);

    logic [NUM_PHASES-1:0] next_warn;
    logic [10:0]           sum;
    logic [2:0]            count;
    logic [10:0]           scaled;
    logic [10:0]           limit;
    logic [4:0]            amps;

    // ----------------------------------------------------------------
    // compare |i*n - sum| > thr*n, which avoids a divider
    // ----------------------------------------------------------------
    always_comb
    begin
        sum       = 11'h000;
        count     = 3'h0;
        scaled    = 11'h000;
        amps      = mfc_share_amps(share_threshold_sel);
        next_warn = '0;
        for (int i = 0; i < NUM_PHASES; i++)
        begin
            if (active[i])
            begin
                sum   = sum + 11'(phase_amps[i]);
                count = count + 3'h1;
            end
        end
        limit = 11'(amps) * 11'(count);
        for (int i = 0; i < NUM_PHASES; i++)
        begin
            scaled = 11'(phase_amps[i]) * 11'(count);
            if (active[i] && amps != 5'h00)
                next_warn[i] = (scaled > sum) ? (scaled - sum > limit)
                                              : (sum - scaled > limit); // RULE16
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            warn <= '0;
        else
            warn <= next_warn;
    end

endmodule : mfc_share_mon

// ### mfc_thresh.sv
// voltage fault thresholds from live setpoints and programmed offsets
module mfc_thresh
    import mfc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [11:0] vout_command_mv,
    input  wire logic [11:0] vout_max_mv,
    input  wire logic [11:0] droop_mv,
    input  wire logic [1:0]  tracking_overvolt_offset,
    input  wire logic [2:0]  fixed_overvolt_offset,
    input  wire logic [2:0]  undervolt_offset,
    output logic      [11:0] track_ov_mv,
    output logic      [11:0] fixed_ov_mv,
    output logic      [11:0] uv_mv
);

    logic [11:0] next_track_ov_mv;
    logic [11:0] next_fixed_ov_mv;
    logic [11:0] next_uv_mv;
    logic [12:0] uv_sub;

    always_comb
    begin
        next_track_ov_mv = vout_command_mv + mfc_track_ov_mv(tracking_overvolt_offset); // RULE9
        next_fixed_ov_mv = vout_max_mv + mfc_fixed_ov_mv(fixed_overvolt_offset); // RULE10
        uv_sub = 13'(vout_command_mv) - 13'(droop_mv) - 13'(mfc_uv_off_mv(undervolt_offset));
        // clamp to zero rather than wrap to a huge threshold
        next_uv_mv = uv_sub[12] ? 12'h000 : uv_sub[11:0]; // RULE11
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            track_ov_mv <= 12'h000;
            fixed_ov_mv <= 12'h000;
            uv_mv       <= 12'h000;
        end
        else
        begin
            track_ov_mv <= next_track_ov_mv;
            fixed_ov_mv <= next_fixed_ov_mv;
            uv_mv       <= next_uv_mv;
        end
    end

endmodule : mfc_thresh

// ### multiphase_fault_config_regs_tb.sv
// self-checking bench for the configuration register bank
module multiphase_fault_config_regs_tb
    import mfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, clear_status, cmd_valid, cmd_write, smfr, siout, alert;
    logic [2:0]                 hw, pcc;
    logic [NUM_PHASES-1:0][7:0] amps;
    logic [11:0]                vc, vm, dr, tov, fov, uv;
    logic [7:0]                 cmd_code, boot;
    logic [15:0]                cmd_wdata, rd_data, q;
    logic [5:0]                 phase_on;
    int fails, num_checks, cnt, mask, a, w, r;
    int th[8] = '{2, 4, 6, 8, 10, 15, 20, 0};
    logic [7:0]  codes[6] = '{8'hE3, 8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hE9};
    logic [15:0] msk[6] = '{16'h0087, 16'h001F, 16'h0007, 16'h00FF, 16'h003F, 16'h0000};

    mfc_host host (.clk(clk), .rd_data(rd_data), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    mfc_regs dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .clear_status(clear_status),
        .hw_phase_code(hw), .phase_amps(amps), .vout_command_mv(vc), .vout_max_mv(vm),
        .droop_mv(dr), .rd_data(rd_data), .phase_on(phase_on), .phase_count_code(pcc),
        .boot_code(boot), .status_mfr_bit3(smfr), .status_iout_bit3(siout),
        .alert_output(alert), .track_ov_mv(tov), .fixed_ov_mv(fov), .uv_mv(uv));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        host.acc(1'b1, c, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        host.acc(1'b0, c, 16'h0000, q);
        chk(q, e, "read data");
    endtask : rd
    task automatic clr();
        @(posedge clk);
        clear_status <= 1'b1;
        @(posedge clk);
        clear_status <= 1'b0;
        cyc(3);
    endtask : clr
    function automatic logic [15:0] exp_on();
        exp_on = '0;
        for (int i = 0; i < 6; i++)
            exp_on[i] = (i <= cnt) && !mask[i];
    endfunction : exp_on
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run is well under a thousand cycles
    initial
    begin
        #100000;
        fails++;
        conclude();
    end

    initial
    begin
        rst_b = 1'b0;
        clear_status = 1'b0;
        hw = 3'h3;
        amps = '0;
        vc = 12'h3E8;
        vm = 12'h7D0;
        dr = 12'h000;
        cnt = 3;
        mask = 0;
        void'($urandom(17));
        cyc(10);
        rst_b <= 1'b1;
        cyc(2);
        rd(8'hE3, 16'h0003);
        rd(8'hE5, 16'h000F);
        rd(8'hE6, 16'h0003);
        rd(8'hE7, 16'h0000);
        rd(8'hE8, 16'h0000);
        rd(8'hE4, 16'h0003);
        chk(phase_on, exp_on(), "phases after reset");
        $display("reset values done");
        for (int i = 0; i < 6; i++)
        begin
            wr(codes[i], 16'hFFFF);
            rd(codes[i], msk[i]);
        end
        wr(8'hE8, 16'h0000);
        $display("reserved bits done");
        for (int k = 0; k < 6; k++)
        begin
            wr(8'hE4, 16'(k));
            if (k <= 3)
                cnt = k;
            cyc(2);
            chk(pcc, 16'(cnt), "phase count");
            chk(phase_on, exp_on(), "live phases");
            chk({smfr, alert}, (k > 3) ? 2'b11 : 2'b00, "count reject");
            rd(8'hE4, 16'(cnt));
            clr();
        end
        $display("phase count done");
        repeat (4)
        begin
            mask = $urandom % 64;
            wr(8'hE8, 16'(mask));
            cyc(2);
            chk(phase_on, exp_on(), "phase mask");
        end
        mask = 0;
        wr(8'hE8, 16'h0000);
        $display("phase mask done");
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clk);
            vc <= 12'(1000 + $urandom % 1000);
            vm <= 12'(2000 + $urandom % 1000);
            dr <= 12'($urandom % 200);
            wr(8'hE5, 16'(((c % 4) << 3) | c));
            wr(8'hE6, 16'(c));
            cyc(3);
            chk(tov, 16'(vc + 175 + 50 * (c % 4)), "tracking ov");
            chk(fov, 16'(vm + 50 * (c + 1)), "fixed ov");
            chk(uv, 16'(vc - dr - ((c == 6) ? 325 : 50 * (c + 1))), "uv");
        end
        $display("thresholds done");
        r = $urandom % 256;
        wr(8'hE7, 16'(16'hA500 | r));
        rd(8'hE7, 16'(r));
        chk(boot, 16'(r), "boot code");
        $display("boot code done");
        for (int c = 0; c < 8; c++)
        begin
            wr(8'hE3, 16'(((c % 2) << 7) | c));
            a = (c == 7) ? 200 : (4 * th[c]) / 3 + 1;
            w = (c != 7);
            @(posedge clk);
            amps[3] <= 8'(a);
            cyc(5);
            chk({siout, alert}, w ? 2'b11 : 2'b00, "share warn");
            chk(phase_on, (w && c % 2 == 0) ? 16'h0007 : 16'h000F, "fault off");
            @(posedge clk);
            amps[3] <= 8'h00;
            clr();
            chk(phase_on, 16'h000F, "restored");
        end
        $display("share warning done");
        conclude();
    end
endmodule : multiphase_fault_config_regs_tb
